// ---- src/slc_cfg.svh ----
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
// register byte offsets
`define SLC_OFF_RAW        12'h004
`define SLC_OFF_STATUS     12'h008
`define SLC_OFF_ENABLE     12'h00c
`define SLC_OFF_CLEAR      12'h010
`define SLC_OFF_SEND_LINK  12'h03c
`define SLC_OFF_RECV_LINK  12'h040
`define SLC_OFF_TOHOST     12'h04c
`define SLC_OFF_TOKEN      12'h050
`define SLC_OFF_CONF1      12'h060
`define SLC_OFF_DSCR_CONF  12'h098
`define SLC_OFF_LEN_CONF   12'h0e4
`define SLC_OFF_LENGTH     12'h0e8
// interrupt bit positions; host-to-slave bits sit at 7..0
`define SLC_EV_SEND_START  8
`define SLC_EV_RECV_START  9
`define SLC_EV_SEND_UDF    10
`define SLC_EV_RECV_OVF    11
`define SLC_EV_RECV_DONE   12
`define SLC_EV_RECV_EOF    13
`define SLC_EV_SEND_DONE   14
`define SLC_EV_SEND_EOF    15
`define SLC_EV_RECV_DERR   16
`define SLC_EV_SEND_DERR   17
`define SLC_NEV            18
// link control fields
`define SLC_LINK_STOP      28
`define SLC_LINK_START     29
`define SLC_LINK_RESTART   30
// descriptor word fields
`define SLC_DSC_OWN        31
`define SLC_DSC_EOF        30
`define SLC_DSC_LEN_HI     29
`define SLC_DSC_LEN_LO     20
// other fields
`define SLC_TOKEN_ADD      12
`define SLC_LEN_ADD        20
`define SLC_CONF1_SEND_JN  0
`define SLC_CONF1_RECV_JN  1
`define SLC_CONF1_LEN_AZ   2
// reset values and implied address bits
`define SLC_ADDR_HI        12'h3ff
`define SLC_RST_KEEP       1'b1
`endif

// ---- src/slc_pkg.sv ----
package slc_pkg;
  typedef enum logic [1:0] {
    FS_IDLE = 2'b01,
    FS_BUSY = 2'b10
  } slc_fetch_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] word;
  } slc_dscr_rsp_type;

  typedef struct packed {
    logic        act;
    logic        ld;
    logic        eof;
    logic [19:0] base;
    logic [19:0] next;
    logic [9:0]  cnt;
  } slc_path_type;
endpackage : slc_pkg

// ---- src/slc_channel.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"

module slc_channel
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // descriptor fetch port
  output var  logic              dscr_req,
  output var  logic [31:0]       dscr_addr,
  input  wire slc_dscr_rsp_type  dscr_rsp,
  // host side strobes
  input  wire logic              send_rd,
  input  wire logic              recv_wr,
  input  wire logic              recv_last,
  input  wire logic [7:0]        host_irq_set,
  // status outputs
  output var  logic              send_buf_ready,
  output var  logic              recv_buf_ready,
  output var  logic [7:0]        host_irq_vec,
  output var  logic              slave_irq
);

  typedef struct packed {
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    slc_fetch_type         fs;
    logic                  fetch_send;
    logic [31:0]           daddr;
    slc_path_type          sp;
    slc_path_type          rp;
    logic [`SLC_NEV-1:0]   raw;
    logic [`SLC_NEV-1:0]   ena;
    logic [7:0]            to_host;
    logic [11:0]           tokens;
    logic [19:0]           plen;
    logic [2:0]            conf1;
    logic                  keep;
    logic                  irq;
  } slc_state_type;

  slc_state_type r;
  slc_state_type s;

  function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
    sel = (a == off);
  endfunction : sel

  // upper address bits are implied, only the low 20 are programmed
  function automatic logic [31:0] full_addr(input logic [19:0] low);
    full_addr = {`SLC_ADDR_HI, low};
  endfunction : full_addr

  function automatic logic [31:0] link_word(input slc_path_type p);
    link_word = {12'h000, p.base};
  endfunction : link_word

  logic                wr;
  logic                hit;
  logic [31:0]         rd;
  logic [`SLC_NEV-1:0] ev;
  logic [`SLC_NEV-1:0] clr;
  logic                dsc_bad;

  always_comb begin
    s       = r;
    ev      = '0;
    clr     = '0;
    rd      = 32'h00000000;
    hit     = 1'b1;
    dsc_bad = 1'b0;
    s.pready  = 1'b0;
    s.pslverr = 1'b0;
    s.to_host = 8'h00;
    ev[7:0]   = host_irq_set;

    // read data is captured one cycle ahead of the completing edge
    if (sel(paddr, `SLC_OFF_RAW)) begin
      rd = {14'h0000, r.raw};
    end else if (sel(paddr, `SLC_OFF_STATUS)) begin
      rd = {14'h0000, r.raw & r.ena};
    end else if (sel(paddr, `SLC_OFF_ENABLE)) begin
      rd = {14'h0000, r.ena};
    end else if (sel(paddr, `SLC_OFF_SEND_LINK)) begin
      rd = link_word(r.sp);
    end else if (sel(paddr, `SLC_OFF_RECV_LINK)) begin
      rd = link_word(r.rp);
    end else if (sel(paddr, `SLC_OFF_TOKEN)) begin
      rd = {20'h00000, r.tokens};
    end else if (sel(paddr, `SLC_OFF_CONF1)) begin
      rd = {29'h00000000, r.conf1};
    end else if (sel(paddr, `SLC_OFF_DSCR_CONF)) begin
      rd = {31'h00000000, r.keep};
    end else if (sel(paddr, `SLC_OFF_LENGTH)) begin
      rd = {12'h000, r.plen};
    end else if (sel(paddr, `SLC_OFF_CLEAR) || sel(paddr, `SLC_OFF_TOHOST)
                 || sel(paddr, `SLC_OFF_LEN_CONF)) begin
      rd = 32'h00000000;
    end else begin
      hit = 1'b0;
    end

    if (psel && penable && !r.pready) begin
      s.pready  = 1'b1;
      s.prdata  = pwrite ? 32'h00000000 : rd;
      s.pslverr = !hit;
    end
    wr = psel && penable && pwrite && r.pready;

    if (wr) begin
      if (sel(paddr, `SLC_OFF_ENABLE)) begin
        s.ena = pwdata[`SLC_NEV-1:0];
      end
      if (sel(paddr, `SLC_OFF_CLEAR)) begin
        clr = pwdata[`SLC_NEV-1:0];
      end
      if (sel(paddr, `SLC_OFF_TOHOST)) begin
        s.to_host = pwdata[7:0];
      end
      if (sel(paddr, `SLC_OFF_TOKEN)) begin
        if (pwdata[`SLC_TOKEN_ADD]) begin
          s.tokens = r.tokens + pwdata[11:0];
        end else begin
          s.tokens = pwdata[11:0];
        end
      end
      if (sel(paddr, `SLC_OFF_LEN_CONF)) begin
        if (pwdata[`SLC_LEN_ADD]) begin
          s.plen = r.plen + pwdata[19:0];
        end else begin
          s.plen = pwdata[19:0];
        end
      end
      if (sel(paddr, `SLC_OFF_CONF1)) begin
        s.conf1 = pwdata[2:0];
      end
      if (sel(paddr, `SLC_OFF_DSCR_CONF)) begin
        s.keep = pwdata[0];
      end
      if (sel(paddr, `SLC_OFF_SEND_LINK)) begin
        s.sp.base = pwdata[19:0];
        if (pwdata[`SLC_LINK_STOP]) begin
          s.sp.act = 1'b0;
          s.sp.ld  = 1'b0;
        end else if (pwdata[`SLC_LINK_START]) begin
          s.sp.act  = 1'b1;
          s.sp.ld   = 1'b0;
          s.sp.next = pwdata[19:0];
          ev[`SLC_EV_SEND_START] = 1'b1;
        end else if (pwdata[`SLC_LINK_RESTART]) begin
          s.sp.act = 1'b1;
        end
      end
      if (sel(paddr, `SLC_OFF_RECV_LINK)) begin
        s.rp.base = pwdata[19:0];
        if (pwdata[`SLC_LINK_STOP]) begin
          s.rp.act = 1'b0;
          s.rp.ld  = 1'b0;
        end else if (pwdata[`SLC_LINK_START]) begin
          s.rp.act  = 1'b1;
          s.rp.ld   = 1'b0;
          s.rp.next = pwdata[19:0];
          ev[`SLC_EV_RECV_START] = 1'b1;
        end else if (pwdata[`SLC_LINK_RESTART]) begin
          s.rp.act = 1'b1;
        end
      end
    end

    // send path: host pulls bytes out of the loaded buffer
    if (send_rd) begin
      if (r.sp.ld && s.sp.ld) begin
        s.sp.cnt = r.sp.cnt - 10'h001;
        if (r.sp.cnt == 10'h001) begin
          s.sp.ld = 1'b0;
          ev[`SLC_EV_SEND_DONE] = 1'b1;
          if (r.sp.eof) begin
            s.sp.act = 1'b0;
            ev[`SLC_EV_SEND_EOF] = 1'b1;
          end
        end
      end else begin
        ev[`SLC_EV_SEND_UDF] = 1'b1;
      end
    end

    // receive path: the packet may close before the buffer fills
    if (recv_wr) begin
      if (r.rp.ld && s.rp.ld) begin
        s.rp.cnt = r.rp.cnt - 10'h001;
        if (r.rp.cnt == 10'h001 || recv_last) begin
          s.rp.ld = 1'b0;
          ev[`SLC_EV_RECV_DONE] = 1'b1;
        end
        if (recv_last) begin
          ev[`SLC_EV_RECV_EOF] = 1'b1;
        end
      end else begin
        ev[`SLC_EV_RECV_OVF] = 1'b1;
      end
    end

    // one shared fetch port; send is served first when both wait
    unique case (r.fs)
      FS_IDLE: begin
        if (s.sp.act && !s.sp.ld) begin
          s.fs         = FS_BUSY;
          s.fetch_send = 1'b1;
          s.daddr      = full_addr(s.sp.next);
        end else if (s.rp.act && !s.rp.ld) begin
          s.fs         = FS_BUSY;
          s.fetch_send = 1'b0;
          s.daddr      = full_addr(s.rp.next);
        end
      end
      FS_BUSY: begin
        if (dscr_rsp.ack) begin
          s.fs    = FS_IDLE;
          dsc_bad = dscr_rsp.err || !dscr_rsp.word[`SLC_DSC_OWN]
                    || (dscr_rsp.word[`SLC_DSC_LEN_HI:`SLC_DSC_LEN_LO] == 10'h000);
          // a stop that lands during the fetch discards the answer
          if (r.fetch_send && s.sp.act) begin
            if (dsc_bad) begin
              s.sp.act = 1'b0;
              ev[`SLC_EV_SEND_DERR] = 1'b1;
            end else begin
              s.sp.ld   = 1'b1;
              s.sp.eof  = dscr_rsp.word[`SLC_DSC_EOF];
              s.sp.cnt  = dscr_rsp.word[`SLC_DSC_LEN_HI:`SLC_DSC_LEN_LO];
              s.sp.next = dscr_rsp.word[19:0];
            end
          end else if (!r.fetch_send && s.rp.act) begin
            if (dsc_bad) begin
              s.rp.act = 1'b0;
              ev[`SLC_EV_RECV_DERR] = 1'b1;
            end else begin
              s.rp.ld   = 1'b1;
              s.rp.eof  = dscr_rsp.word[`SLC_DSC_EOF];
              s.rp.cnt  = dscr_rsp.word[`SLC_DSC_LEN_HI:`SLC_DSC_LEN_LO];
              s.rp.next = dscr_rsp.word[19:0];
            end
          end
        end
      end
    endcase

    // a new event beats a clear in the same cycle
    s.raw = (r.raw & ~clr) | ev;
    s.irq = |(s.raw & s.ena);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r            <= '0;
      r.fs         <= FS_IDLE;
      r.keep       <= `SLC_RST_KEEP;
    end else begin
      r <= s;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  // the one-hot busy code is its own request flop, so no decode sits on the pin
  assign dscr_req       = r.fs[1];
  assign dscr_addr      = r.daddr;
  assign send_buf_ready = r.sp.ld;
  assign recv_buf_ready = r.rp.ld;
  assign host_irq_vec   = r.to_host;
  assign slave_irq      = r.irq;

endmodule : slc_channel
`default_nettype wire

// ---- verif/slc_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
module slc_checker
  import slc_pkg::*;
(
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // fetch and host side
  input wire logic             dscr_req,
  input wire logic [31:0]      dscr_addr,
  input wire slc_dscr_rsp_type dscr_rsp,
  input wire logic [7:0]       host_irq_vec,
  input wire logic             slave_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        wr_done;
  logic [19:0] base_r;
  assign wr_done = psel && penable && pready && pwrite;
  // keeps the last written low address so a fetch can be matched to its start write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) base_r <= '0;
    else if (wr_done) base_r <= pwdata[19:0];
  end
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  fetch_hold_a: assert property (dscr_req && !dscr_rsp.ack |=> dscr_req && $stable(dscr_addr))
    else $error("fetch request moved");
  fetch_drop_a: assert property (dscr_req && dscr_rsp.ack |=> !dscr_req)
    else $error("fetch held after ack");
  addr_high_a: assert property (dscr_req |-> dscr_addr[31:20] == `SLC_ADDR_HI)
    else $error("implied address bits wrong");
  send_start_a: assert property (wr_done && paddr == `SLC_OFF_SEND_LINK && pwdata[`SLC_LINK_START]
    && !pwdata[`SLC_LINK_STOP] |-> ##[1:8] dscr_req && dscr_addr[19:0] == base_r)
    else $error("send walk not at base");
  recv_start_a: assert property (wr_done && paddr == `SLC_OFF_RECV_LINK && pwdata[`SLC_LINK_START]
    && !pwdata[`SLC_LINK_STOP] |-> ##[1:8] dscr_req && dscr_addr[19:0] == base_r)
    else $error("receive walk not at base");
  vec_pulse_a: assert property (wr_done && paddr == `SLC_OFF_TOHOST |=> host_irq_vec == $past(pwdata[7:0]))
    else $error("host vector not raised");
  irq_mask_a: assert property (wr_done && paddr == `SLC_OFF_ENABLE && pwdata == 32'h0 |=> ##1 !slave_irq)
    else $error("irq while all masked");
endmodule : slc_checker
bind slc_channel slc_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .dscr_req, .dscr_addr, .dscr_rsp, .host_irq_vec, .slave_irq);
`default_nettype wire

// ---- verif/slc_dscr_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module slc_dscr_model
  import slc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // fetch port
  input  wire logic        dscr_req,
  input  wire logic [31:0] dscr_addr,
  output var  slc_dscr_rsp_type dscr_rsp,
  // bench controls
  input  wire logic [3:0]  lat,
  input  wire logic        fail
);
  logic [3:0]  cnt;
  logic        ack;
  logic [31:0] w;
  // 0x10 -> 0x20 (last) for sending, 0x30 loops on itself for receiving, rest unowned
  function automatic logic [31:0] mem(input logic [7:0] a);
    case (a)
      8'h10:   return {1'b1, 1'b0, 10'h002, 20'h00020};
      8'h20:   return {1'b1, 1'b1, 10'h001, 20'h00000};
      8'h30:   return {1'b1, 1'b0, 10'h002, 20'h00030};
      default: return 32'h0;
    endcase
  endfunction : mem
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {cnt, ack, w} <= '0;
    else if (ack) {cnt, ack} <= '0;
    else if (dscr_req && cnt >= lat) {ack, w} <= {1'b1, mem(dscr_addr[7:0])};
    else if (dscr_req) cnt <= cnt + 4'h1;
  end
  // word inverted outside the answer cycle so stale data cannot pass
  assign dscr_rsp = '{ack: ack, err: ack && fail, word: ack ? w : ~w};
endmodule : slc_dscr_model
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
`define CHK(n,e,a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_top
  import slc_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        send_rd = 0, recv_wr = 0, recv_last = 0, fail = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, dscr_addr, rd;
  logic [7:0]  host_irq_set = '0, host_irq_vec;
  logic [3:0]  lat = '0;
  logic        pready, pslverr, dscr_req, send_buf_ready, recv_buf_ready, slave_irq;
  slc_dscr_rsp_type dscr_rsp;
  int          n_errors = 0, cmp_count = 0;
  slc_channel dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dscr_req, .dscr_addr, .dscr_rsp, .send_rd, .recv_wr, .recv_last, .host_irq_set, .send_buf_ready,
    .recv_buf_ready, .host_irq_vec, .slave_irq);
  slc_dscr_model host (.pclk, .presetn, .dscr_req, .dscr_addr, .dscr_rsp, .lat, .fail);
  always #2.5 pclk = ~pclk;
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (i == 9) begin n_errors++; complete_run(); end
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask : rc
  // waits for send ready (0), receive ready (1) or a fetch (2)
  task automatic tw(input int k);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge pclk);
      if ((k == 0 ? send_buf_ready : k == 1 ? recv_buf_ready : dscr_req) === 1'b1) break;
    end
    if (i == 60) begin n_errors++; complete_run(); end
  endtask : tw
  task automatic st(input int k, input int n, input logic last);
    repeat (n) begin
      @(posedge pclk);
      {send_rd, recv_wr, recv_last} <= {k == 0, k == 1, last};
      @(posedge pclk);
      {send_rd, recv_wr, recv_last} <= 3'b000;
    end
    repeat (2) @(posedge pclk);
  endtask : st
  task automatic t_regs();
    rc(`SLC_OFF_DSCR_CONF, 32'h1, "keep flag");
    apb(1'b1, `SLC_OFF_CONF1, 32'h0);
    apb(1'b1, `SLC_OFF_DSCR_CONF, 32'h1);
    rc(`SLC_OFF_ENABLE, 32'h0, "enable reset");
    apb(1'b1, `SLC_OFF_ENABLE, 32'h3ffff);
    rc(`SLC_OFF_ENABLE, 32'h3ffff, "enable");
    apb(1'b1, `SLC_OFF_LENGTH, 32'hff);
    rc(`SLC_OFF_LENGTH, 32'h0, "length");
    rc(12'hffc, 32'h0, "unmapped");
    `CHK("unmapped err", 1'b1, err)
  endtask : t_regs
  task automatic t_host();
    @(posedge pclk);
    host_irq_set <= 8'h80;
    @(posedge pclk);
    host_irq_set <= 8'h00;
    rc(`SLC_OFF_STATUS, 32'h80, "status");
    `CHK("irq", 1'b1, slave_irq)
    apb(1'b1, `SLC_OFF_ENABLE, 32'h0);
    rc(`SLC_OFF_STATUS, 32'h0, "masked");
    apb(1'b1, `SLC_OFF_CLEAR, 32'h0);
    apb(1'b1, `SLC_OFF_ENABLE, 32'h3ffff);
    rc(`SLC_OFF_STATUS, 32'h80, "kept");
    apb(1'b1, `SLC_OFF_CLEAR, 32'h80);
    rc(`SLC_OFF_RAW, 32'h0, "cleared");
    apb(1'b1, `SLC_OFF_TOHOST, 32'ha5);
    // the vector stands for the one cycle after the completing edge
    @(posedge pclk);
    `CHK("host vector", 8'ha5, host_irq_vec)
  endtask : t_host
  task automatic t_count();
    apb(1'b1, `SLC_OFF_TOKEN, 32'h5);
    rc(`SLC_OFF_TOKEN, 32'h5, "tokens");
    apb(1'b1, `SLC_OFF_TOKEN, 32'h1003);
    rc(`SLC_OFF_TOKEN, 32'h8, "tokens add");
    apb(1'b1, `SLC_OFF_LEN_CONF, 32'h10);
    apb(1'b1, `SLC_OFF_LEN_CONF, 32'h100005);
    rc(`SLC_OFF_LENGTH, 32'h15, "length add");
  endtask : t_count
  task automatic t_send();
    apb(1'b1, `SLC_OFF_CLEAR, 32'h3ffff);
    apb(1'b1, `SLC_OFF_SEND_LINK, 32'h20000010);
    tw(0);
    st(0, 2, 1'b0);
    tw(0);
    st(0, 2, 1'b0);
    rc(`SLC_OFF_RAW, 32'hc500, "send events");
    `CHK("irq on", 1'b1, slave_irq)
    apb(1'b1, `SLC_OFF_CLEAR, 32'h3ffff);
    lat <= 4'h3;
    apb(1'b1, `SLC_OFF_SEND_LINK, 32'h20000050);
    repeat (12) @(posedge pclk);
    rc(`SLC_OFF_RAW, 32'h20100, "send fault");
  endtask : t_send
  task automatic t_recv();
    apb(1'b1, `SLC_OFF_CLEAR, 32'h3ffff);
    lat <= 4'h0;
    apb(1'b1, `SLC_OFF_RECV_LINK, 32'h20000030);
    tw(1);
    fail <= 1'b1;
    st(1, 2, 1'b0);
    repeat (6) @(posedge pclk);
    st(1, 1, 1'b0);
    rc(`SLC_OFF_RAW, 32'h11a00, "recv events");
    fail <= 1'b0;
    apb(1'b1, `SLC_OFF_RECV_LINK, 32'h40000000);
    tw(2);
    `CHK("resume addr", 20'h00030, dscr_addr[19:0])
    tw(1);
    apb(1'b1, `SLC_OFF_CLEAR, 32'h3ffff);
    st(1, 1, 1'b1);
    rc(`SLC_OFF_RAW, 32'h3000, "recv end");
    tw(1);
    apb(1'b1, `SLC_OFF_RECV_LINK, 32'h10000000);
    st(1, 2, 1'b0);
    repeat (10) begin
      @(posedge pclk);
      `CHK("stopped", 1'b0, dscr_req)
    end
    // a stopped path holds no buffer, so both writes must overflow
    rc(`SLC_OFF_RAW, 32'h3800, "stop overflow");
  endtask : t_recv
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_host();
    t_count();
    t_send();
    t_recv();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
